/* File: common/imc_pkg.sv */
package imc_pkg;
    // Source count and mask weights.
    localparam int NUM_SRC = 5;
    localparam int SRC_A = 0;
    localparam int SRC_B = 1;
    localparam int SRC_C = 2;
    localparam int SRC_D = 3;
    localparam int SRC_TMR = 4;
    localparam logic [4:0] MASK_NONE = 5'h00;
    localparam logic [4:0] MASK_ALL = 5'h1f;
    localparam int LABEL_W = 16;
    localparam logic [LABEL_W-1:0] LABEL_RESET = 16'h0000;
    localparam logic [2:0] SRC_IDLE = 3'h7;
    typedef enum logic [1:0] {
        IMC_RUN,
        IMC_HANDLER
    } imc_state_t;
endpackage : imc_pkg

/* File: rtl/imc_mask_control.sv */
`timescale 1ns/100ps
`default_nettype none

module imc_mask_control (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Source configuration.
    input wire logic [4:0] srcConfigured,
    // Commands from the sequencer.
    input wire logic maskOffCommand,
    input wire logic maskOnCommand,
    input wire logic [4:0] sourceSelectMask,
    // Handler label writes.
    input wire logic labelWrite,
    input wire logic [2:0] labelIndex,
    input wire logic [15:0] labelData,
    // Trigger inputs.
    input wire logic extIrqA,
    input wire logic extIrqB,
    input wire logic extIrqC,
    input wire logic extIrqD,
    input wire logic timerTick,
    // Handler return and error clear.
    input wire logic handlerReturn,
    input wire logic errorClear,
    // Status.
    output logic [4:0] enabledStatus,
    output logic programExecErrorFlag,
    output logic errorLed,
    // Dispatch.
    output logic dispatchValid,
    output logic [2:0] dispatchSource,
    output logic [15:0] dispatchLabel,
    output logic inHandler
);

    logic [4:0] enable_q, enable_d;
    logic err_q, err_d;
    logic [4:0] trigPrev_q, trigPrev_d;
    logic [15:0] label_q [imc_pkg::NUM_SRC];
    logic [15:0] label_d [imc_pkg::NUM_SRC];
    imc_pkg::imc_state_t state_q, state_d;
    logic [2:0] curSrc_q, curSrc_d;
    logic dispV_q, dispV_d;
    logic [15:0] dispL_q, dispL_d;
    logic [4:0] trig, rise, pend;
    logic cmd, badCmd;
    logic [2:0] pick;

    assign trig = {timerTick, extIrqD, extIrqC, extIrqB, extIrqA};
    assign rise = trig & ~trigPrev_q;
    assign cmd = maskOffCommand | maskOnCommand;

    // ------------------------------------------------------------
    // Enable mask and error flag
    // ------------------------------------------------------------

    always_comb begin
        enable_d = enable_q;
        err_d = err_q;
        badCmd = cmd && (((sourceSelectMask & ~srcConfigured) != imc_pkg::MASK_NONE)
                 || state_q == imc_pkg::IMC_HANDLER
                 || sourceSelectMask == imc_pkg::MASK_NONE);
        if (cmd && !badCmd) begin
            if (maskOffCommand) begin
                enable_d = enable_q & ~sourceSelectMask;
            end
            else begin
                enable_d = enable_q | sourceSelectMask;
            end
        end
        if (errorClear) begin
            err_d = 1'b0;
        end
        if (badCmd) begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            enable_q <= imc_pkg::MASK_ALL;
            err_q <= 1'b0;
        end else begin
            enable_q <= enable_d;
            err_q <= err_d;
        end
    end

    assign enabledStatus = enable_q & srcConfigured;
    assign programExecErrorFlag = err_q;
    assign errorLed = err_q;

    // ------------------------------------------------------------
    // Handler labels
    // ------------------------------------------------------------

    always_comb begin
        for (int i = 0; i < imc_pkg::NUM_SRC; i++) begin
            label_d[i] = label_q[i];
        end
        if (labelWrite && labelIndex < 3'(imc_pkg::NUM_SRC)) begin
            label_d[labelIndex] = labelData;
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < imc_pkg::NUM_SRC; i++) begin
            if (reset) begin
                label_q[i] <= imc_pkg::LABEL_RESET;
            end else begin
                label_q[i] <= label_d[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Dispatch
    // ------------------------------------------------------------

    assign pend = rise & enable_q & srcConfigured;

    always_comb begin
        pick = imc_pkg::SRC_IDLE;
        for (int i = imc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                pick = 3'(i);
            end
        end
    end

    always_comb begin
        state_d = state_q;
        curSrc_d = curSrc_q;
        dispV_d = 1'b0;
        dispL_d = dispL_q;
        trigPrev_d = trig;
        unique case (state_q)
            imc_pkg::IMC_RUN: begin
                if (pick != imc_pkg::SRC_IDLE) begin
                    state_d = imc_pkg::IMC_HANDLER;
                    curSrc_d = pick;
                    dispV_d = 1'b1;
                    dispL_d = label_q[pick];
                end
            end
            imc_pkg::IMC_HANDLER: begin
                if (handlerReturn) begin
                    state_d = imc_pkg::IMC_RUN;
                    curSrc_d = imc_pkg::SRC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= imc_pkg::IMC_RUN;
            curSrc_q <= imc_pkg::SRC_IDLE;
            dispV_q <= 1'b0;
            dispL_q <= imc_pkg::LABEL_RESET;
            trigPrev_q <= imc_pkg::MASK_NONE;
        end else begin
            state_q <= state_d;
            curSrc_q <= curSrc_d;
            dispV_q <= dispV_d;
            dispL_q <= dispL_d;
            trigPrev_q <= trigPrev_d;
        end
    end

    assign dispatchValid = dispV_q;
    assign dispatchSource = curSrc_q;
    assign dispatchLabel = dispL_q;
    assign inHandler = (state_q == imc_pkg::IMC_HANDLER);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    a_off_clears: assert property (@(posedge core_clk) disable iff (reset)
        maskOffCommand && !maskOnCommand && !badCmd |=> (enable_q & $past(sourceSelectMask)) == 5'h00)
        else $error("mask-off left a named source enabled");
    a_on_sets: assert property (@(posedge core_clk) disable iff (reset)
        maskOnCommand && !maskOffCommand && !badCmd
        |=> (enable_q & $past(sourceSelectMask)) == $past(sourceSelectMask))
        else $error("mask-on left a named source disabled");
    a_others_kept: assert property (@(posedge core_clk) disable iff (reset)
        cmd |=> (enable_q & ~$past(sourceSelectMask)) == ($past(enable_q) & ~$past(sourceSelectMask)))
        else $error("command touched an unnamed source");
    a_reset_enabled: assert property (@(posedge core_clk)
        $past(reset) |-> enable_q == 5'h1f)
        else $error("sources not enabled after reset");
    a_no_disabled: assert property (@(posedge core_clk) disable iff (reset)
        dispatchValid |-> ($past(enable_q) & (5'h01 << dispatchSource)) != imc_pkg::MASK_NONE)
        else $error("disabled source dispatched");
    a_unconf_err: assert property (@(posedge core_clk) disable iff (reset)
        cmd && (sourceSelectMask & ~srcConfigured) != 5'h00 |=> programExecErrorFlag && errorLed)
        else $error("unconfigured source did not raise error");
    a_handler_err: assert property (@(posedge core_clk) disable iff (reset)
        cmd && inHandler |=> programExecErrorFlag ##0 $stable(enable_q))
        else $error("command in handler not flagged");
    a_err_sticky: assert property (@(posedge core_clk) disable iff (reset)
        programExecErrorFlag && !errorClear |=> programExecErrorFlag)
        else $error("error flag dropped without clear");
    a_dispatch_label: assert property (@(posedge core_clk) disable iff (reset)
        dispatchValid |-> dispatchLabel == $past(label_q[pick]) && inHandler)
        else $error("dispatch label mismatch");

    // ------------------------------------------------------------
    // Further checks
    // ------------------------------------------------------------

    a_zero_mask_err: assert property (@(posedge core_clk) disable iff (reset)
        cmd && sourceSelectMask == imc_pkg::MASK_NONE |=> programExecErrorFlag)
        else $error("empty mask not flagged");
    a_zero_mask_kept: assert property (@(posedge core_clk) disable iff (reset)
        cmd && sourceSelectMask == imc_pkg::MASK_NONE |=> $stable(enable_q))
        else $error("empty mask changed enables");
    a_unconf_kept: assert property (@(posedge core_clk) disable iff (reset)
        cmd && (sourceSelectMask & ~srcConfigured) != imc_pkg::MASK_NONE |=> $stable(enable_q))
        else $error("refused command changed enables");
    a_led_follows: assert property (@(posedge core_clk) disable iff (reset)
        errorLed == programExecErrorFlag)
        else $error("error indicator differs from flag");
    a_handler_led: assert property (@(posedge core_clk) disable iff (reset)
        cmd && inHandler |=> errorLed)
        else $error("command in handler did not light indicator");
    a_err_clear: assert property (@(posedge core_clk) disable iff (reset)
        errorClear && !badCmd |=> !programExecErrorFlag)
        else $error("error clear ignored");
    a_err_set_wins: assert property (@(posedge core_clk) disable iff (reset)
        errorClear && badCmd |=> programExecErrorFlag)
        else $error("clear beat a new error");
    a_err_no_rise: assert property (@(posedge core_clk) disable iff (reset)
        !programExecErrorFlag && !badCmd |=> !programExecErrorFlag)
        else $error("error flag rose without misuse");
    a_status_hold: assert property (@(posedge core_clk) disable iff (reset)
        !cmd ##1 $stable(srcConfigured) |-> $stable(enabledStatus))
        else $error("status changed without command");
    a_off_wins: assert property (@(posedge core_clk) disable iff (reset)
        maskOffCommand && maskOnCommand && !badCmd
        |=> (enable_q & $past(sourceSelectMask)) == imc_pkg::MASK_NONE)
        else $error("mask-off did not win over mask-on");
    a_no_early_change: assert property (@(posedge core_clk) disable iff (reset)
        !cmd |=> $stable(enable_q))
        else $error("enables changed without command");
    a_disp_pulse: assert property (@(posedge core_clk) disable iff (reset)
        dispatchValid |=> !dispatchValid)
        else $error("dispatch pulse longer than one cycle");
    a_disp_from_run: assert property (@(posedge core_clk) disable iff (reset)
        dispatchValid |-> $past(!inHandler))
        else $error("dispatch while handler ran");
    a_handler_ret: assert property (@(posedge core_clk) disable iff (reset)
        inHandler && handlerReturn |=> !inHandler && dispatchSource == imc_pkg::SRC_IDLE)
        else $error("handler return did not resume main");
    a_handler_stay: assert property (@(posedge core_clk) disable iff (reset)
        inHandler && !handlerReturn |=> inHandler && $stable(dispatchSource))
        else $error("handler left without return");
    a_disp_enters: assert property (@(posedge core_clk) disable iff (reset)
        dispatchValid |-> inHandler)
        else $error("dispatch without handler entry");
    a_idle_source: assert property (@(posedge core_clk) disable iff (reset)
        !inHandler |-> dispatchSource == imc_pkg::SRC_IDLE)
        else $error("source shown outside handler");
    a_no_disp_handler: assert property (@(posedge core_clk) disable iff (reset)
        inHandler |=> !dispatchValid)
        else $error("trigger dispatched during handler");
    a_label_keep: assert property (@(posedge core_clk) disable iff (reset)
        !labelWrite |=> $stable(label_q[imc_pkg::SRC_A]))
        else $error("label changed without write");
    a_label_write: assert property (@(posedge core_clk) disable iff (reset)
        labelWrite && labelIndex == 3'(imc_pkg::SRC_B) |=> label_q[imc_pkg::SRC_B] == $past(labelData))
        else $error("label write lost");
    a_enabled_dispatch: assert property (@(posedge core_clk) disable iff (reset)
        $rose(extIrqA) && enable_q[imc_pkg::SRC_A] && srcConfigured[imc_pkg::SRC_A] && !inHandler
        |=> dispatchValid)
        else $error("enabled input not dispatched");

endmodule : imc_mask_control

`default_nettype wire

/* File: tb/imc_mask_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module imc_mask_control_tb;
    logic core_clk, reset, errorClear;
    logic [4:0] srcConfigured, irq, enabledStatus, sm;
    logic moff, mon, lw, hr, flag, led, dv, inH;
    logic [2:0] li, ds;
    logic [15:0] ld, dl;
    int badCount = 0;
    int nTests = 0;
    imc_seq_model u_seq (.core_clk(core_clk), .maskOffCommand(moff), .maskOnCommand(mon),
        .sourceSelectMask(sm), .labelWrite(lw), .labelIndex(li), .labelData(ld), .handlerReturn(hr));
    imc_mask_control dut (.core_clk(core_clk), .reset(reset), .srcConfigured(srcConfigured),
        .maskOffCommand(moff), .maskOnCommand(mon), .sourceSelectMask(sm), .labelWrite(lw),
        .labelIndex(li), .labelData(ld), .extIrqA(irq[0]), .extIrqB(irq[1]), .extIrqC(irq[2]),
        .extIrqD(irq[3]), .timerTick(irq[4]), .handlerReturn(hr), .errorClear(errorClear),
        .enabledStatus(enabledStatus), .programExecErrorFlag(flag), .errorLed(led),
        .dispatchValid(dv), .dispatchSource(ds), .dispatchLabel(dl), .inHandler(inH));
    // ----------------------------------------
    // Checking and closing.
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic endSim();
        $display("checks %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : endSim
    task automatic trig(input int i, input logic en);
        logic seen;
        seen = 1'b0;
        @(posedge core_clk);
        #1;
        irq[i] = 1'b1;
        repeat (4) begin
            @(posedge core_clk);
            #1;
            if (dv === 1'b1) begin
                seen = 1'b1;
                chk({13'h0, ds}, 16'(i));
                chk(dl, 16'h00a0 + 16'(i));
            end
        end
        irq[i] = 1'b0;
        chk({15'h0, seen}, {15'h0, en});
    endtask : trig
    task automatic tMasks();
        u_seq.cmd(1'b1, 5'h13);
        chk({11'h0, enabledStatus}, 16'h000c);
        u_seq.cmd(1'b0, 5'h03);
        chk({11'h0, enabledStatus}, 16'h000f);
        u_seq.cmd(1'b0, 5'h10);
        chk({11'h0, enabledStatus}, 16'h001f);
    endtask : tMasks
    task automatic tDispatch();
        u_seq.cmd(1'b1, 5'h01);
        trig(0, 1'b0);
        u_seq.cmd(1'b0, 5'h01);
        for (int i = 0; i < 5; i++) begin
            trig(i, 1'b1);
            chk({15'h0, inH}, 16'h0001);
            u_seq.cmd(1'b1, 5'h02);
            chk({14'h0, flag, led}, 16'h0003);
            chk({11'h0, enabledStatus}, 16'h001f);
            u_seq.ret();
            chk({13'h0, inH, ds[1:0]}, 16'h0003);
            errorClear = 1'b1;
            @(posedge core_clk);
            #1;
            errorClear = 1'b0;
            chk({15'h0, flag}, 16'h0000);
        end
    endtask : tDispatch
    task automatic tUnconf();
        srcConfigured = 5'h1e;
        u_seq.cmd(1'b0, 5'h01);
        repeat (3) @(posedge core_clk);
        #1;
        chk({14'h0, flag, led}, 16'h0003);
        chk({11'h0, enabledStatus}, 16'h001e);
        srcConfigured = 5'h1f;
    endtask : tUnconf
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        badCount++;
        endSim();
    end
    initial begin
        {reset, errorClear, srcConfigured, irq} = {2'h2, 5'h1f, 5'h00};
        repeat (4) @(posedge core_clk);
        #1;
        reset = 1'b0;
        chk({11'h0, enabledStatus}, 16'h001f);
        chk({12'h0, flag, ds}, 16'h0007);
        for (int i = 0; i < 5; i++) u_seq.wrLabel(3'(i), 16'h00a0 + 16'(i));
        tMasks();
        tDispatch();
        tUnconf();
        endSim();
    end
endmodule : imc_mask_control_tb
`default_nettype wire

/* File: tb/imc_seq_model.sv */
`timescale 1ns/100ps
`default_nettype none
module imc_seq_model (
    // Clock.
    input wire logic core_clk,
    // Commands, label writes and handler return.
    output logic maskOffCommand,
    output logic maskOnCommand,
    output logic [4:0] sourceSelectMask,
    output logic labelWrite,
    output logic [2:0] labelIndex,
    output logic [15:0] labelData,
    output logic handlerReturn
);
    initial begin
        {maskOffCommand, maskOnCommand, labelWrite, handlerReturn} = 4'h0;
        {sourceSelectMask, labelIndex, labelData} = 24'h000000;
    end
    task automatic cmd(input logic off, input logic [4:0] m);
        @(posedge core_clk);
        #1;
        {maskOffCommand, maskOnCommand, sourceSelectMask} = {off, ~off, m};
        @(posedge core_clk);
        #1;
        {maskOffCommand, maskOnCommand, sourceSelectMask} = {2'h0, ~m};
    endtask : cmd
    task automatic wrLabel(input logic [2:0] i, input logic [15:0] d);
        @(posedge core_clk);
        #1;
        {labelWrite, labelIndex, labelData} = {1'b1, i, d};
        @(posedge core_clk);
        #1;
        {labelWrite, labelIndex, labelData} = {1'b0, ~i, ~d};
    endtask : wrLabel
    task automatic ret();
        @(posedge core_clk);
        #1;
        handlerReturn = 1'b1;
        @(posedge core_clk);
        #1;
        handlerReturn = 1'b0;
    endtask : ret
endmodule : imc_seq_model
`default_nettype wire
